// ---- design/ssq_pkg.sv ----
// shared constants and types of the sample sequencer
package ssq_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int RES_W = 10;
    localparam int BUF_WORDS = 16;
    localparam int NUM_INPUTS = 16;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_INSEL = 8'h08;
    localparam logic [7:0] OFF_SCAN = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_TRIG = 8'h18;
    localparam logic [7:0] OFF_STATE = 8'h1C;
    localparam logic [7:0] OFF_BUF = 8'h40;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_AUTO_BIT = 1;
    localparam int CTL_TOGETHER_BIT = 2;
    localparam int CTL_SPLIT_BIT = 3;
    localparam int C2_ALT_BIT = 0;
    localparam int C2_SPI_LSB = 2;
    localparam int C2_CHCNT_LSB = 8;
    localparam int C2_SCAN_BIT = 10;
    localparam int IS_C0P_A_LSB = 0;
    localparam int IS_C0N_A_BIT = 4;
    localparam int IS_C13P_A_BIT = 5;
    localparam int IS_C13N_A_LSB = 6;
    localparam int IS_C0P_B_LSB = 8;
    localparam int IS_C0N_B_BIT = 12;
    localparam int IS_C13P_B_BIT = 13;
    localparam int IS_C13N_B_LSB = 14;
    localparam int ST_SEQ_BIT = 0;
    localparam int ST_CONV_BIT = 1;
    localparam int TRG_SAMPLE_BIT = 0;
    localparam int TRG_CONVERT_BIT = 1;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [1:0] CHCNT_ONE = 2'h0;
    localparam logic [1:0] CHCNT_TWO = 2'h1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SSQ_IDLE,
        SSQ_SAMPLE,
        SSQ_START,
        SSQ_WAIT
    } ssq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } ssq_bus_req_t;

    // input routing per sample-and-hold channel; neg_ref high selects the negative reference
    typedef struct packed {
        logic [3:0][3:0] pos;
        logic [3:0][3:0] neg;
        logic [3:0] neg_ref;
    } ssq_mux_t;

endpackage

// ---- design/ssq_scan_picker.sv ----
// picks the first and the next enabled input of the scan mask
`timescale 1ns/10ps
module ssq_scan_picker (
    // scan mask and position
    input wire logic [15:0] mask_i,
    input wire logic [3:0] cur_i,
    // choices
    output logic [3:0] first_o,
    output logic [3:0] next_o
);
    import ssq_pkg::*;

    // lowest enabled input at or above from, wrapping; input 0 when the mask is empty
    function automatic logic [3:0] pick(input logic [15:0] mask, input logic [3:0] from);
        logic [3:0] idx;
        logic found;
        pick = 4'h0;
        found = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            idx = from + 4'(i);
            if (!found && mask[idx]) begin
                pick = idx;
                found = 1'b1;
            end
        end
    endfunction

    always_comb begin
        first_o = pick(mask_i, 4'h0);
        next_o = pick(mask_i, cur_i + 4'h1);
    end
endmodule

// ---- design/ssq_result_buffer.sv ----
// sixteen-word result store with one write and one read port
`timescale 1ns/10ps
module ssq_result_buffer (
    // clock
    input wire logic mclk_i,
    // write side
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [9:0] wdata_i,
    // read side
    input wire logic [3:0] raddr_i,
    output logic [9:0] rdata_o
);
    import ssq_pkg::*;

    logic [RES_W-1:0] mem [BUF_WORDS];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];
endmodule

// ---- design/ssq_sequencer.sv ----
// sample and conversion sequencer of a successive-approximation converter
//
// Behaviour
// - single channel, fixed input: one result per conversion, interrupt after sequences-per-interrupt plus one results
// - interrupt after sequences-per-interrupt plus one sequences; all ones gives sixteen
// - channel count zero code uses channel 0 only, channels 1 to 3 inactive
// - alternate-set bit clear: always first input set, never the second
// - buffer-split bit clear: one sixteen-word buffer
// - channel 0 positive field zero routes input 0; negative bit clear routes reference
// - scan enable, bit 10 of second control register, overrides channel 0 positive field
// - scanning steps ascending from the lowest enabled input of the scan mask, next enabled input each sample
// - each result goes to the next buffer word, from word 0 to 15
// - after interrupt the sequence restarts from word 0 without software
// - four channels together: all sampled at one instant before any conversion
// - after multi-channel sample convert the active channels in order 0,1,2,3 into consecutive words
// - scan with four channels advances channel 0 only; others keep fixed inputs 0,1,2 or 3,4,5
// - single channel ignores the together-versus-sequential setting
// - inactive channels and unused input set fields are disregarded
// - auto-sample starts sampling; a conversion trigger ends it and starts conversion
// - together mode samples all channels first, then converts them one by one
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module ssq_sequencer (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire ssq_pkg::ssq_bus_req_t bus_i,
    output logic [15:0] rdata_o,
    // external conversion trigger pin
    input wire logic conv_trigger_i,
    // converter core
    input wire logic conv_done_i,
    input wire logic [9:0] conv_result_i,
    output logic conv_start_o,
    output logic [1:0] conv_channel_o,
    output logic [3:0] sample_o,
    // input multiplexers
    output ssq_pkg::ssq_mux_t mux_o,
    // interrupt
    output logic irq_o
);
    import ssq_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [1:0] last_chan(input logic [1:0] code);
        case (code)
            CHCNT_ONE: last_chan = 2'h0;
            CHCNT_TWO: last_chan = 2'h1;
            default: last_chan = 2'h3;
        endcase
    endfunction

    function automatic logic [3:0] active_mask(input logic [1:0] code);
        case (code)
            CHCNT_ONE: active_mask = 4'h1;
            CHCNT_TWO: active_mask = 4'h3;
            default: active_mask = 4'hF;
        endcase
    endfunction

    function automatic logic is_addr(input ssq_bus_req_t req, input logic [7:0] off);
        is_addr = (req.addr == off);
    endfunction

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] insel;
    logic [15:0] scan_select_mask;
    logic [15:0] status;
    logic [15:0] irq_mask;

    logic enable;
    logic auto_sample_enable;
    logic sample_together_select;
    logic buffer_split_select;
    logic alternate_set_select;
    logic [3:0] sequences_per_interrupt;
    logic [1:0] channel_count_select;
    logic scan_enable;

    assign enable = ctrl1[CTL_ENABLE_BIT];
    assign auto_sample_enable = ctrl1[CTL_AUTO_BIT];
    assign sample_together_select = ctrl1[CTL_TOGETHER_BIT];
    assign buffer_split_select = ctrl1[CTL_SPLIT_BIT];
    assign alternate_set_select = ctrl2[C2_ALT_BIT];
    assign sequences_per_interrupt = ctrl2[C2_SPI_LSB +: 4];
    assign channel_count_select = ctrl2[C2_CHCNT_LSB +: 2];
    assign scan_enable = ctrl2[C2_SCAN_BIT];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1 <= RST_REG;
            ctrl2 <= RST_REG;
            insel <= RST_REG;
            scan_select_mask <= RST_REG;
            irq_mask <= RST_REG;
        end else if (bus_i.we) begin
            if (is_addr(bus_i, OFF_CTRL1)) begin
                ctrl1 <= {12'h000, bus_i.wdata[3:0]};
            end
            if (is_addr(bus_i, OFF_CTRL2)) begin
                ctrl2 <= {5'h00, bus_i.wdata[10:8], 2'h0, bus_i.wdata[5:2], 1'b0, bus_i.wdata[0]};
            end
            if (is_addr(bus_i, OFF_INSEL)) begin
                insel <= bus_i.wdata;
            end
            if (is_addr(bus_i, OFF_SCAN)) begin
                scan_select_mask <= bus_i.wdata;
            end
            if (is_addr(bus_i, OFF_MASK)) begin
                irq_mask <= {14'h0000, bus_i.wdata[1:0]};
            end
        end
    end

    // ****************************************
    // trigger pin synchroniser and software strobes
    // ****************************************
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic sw_sample;
    logic sw_convert;
    logic conv_trigger;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= conv_trigger_i;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    assign sw_sample = bus_i.we && is_addr(bus_i, OFF_TRIG) && bus_i.wdata[TRG_SAMPLE_BIT];
    assign sw_convert = bus_i.we && is_addr(bus_i, OFF_TRIG) && bus_i.wdata[TRG_CONVERT_BIT];
    assign conv_trigger = sw_convert || (trig_sync && !trig_prev);

    // ****************************************
    // sequence state
    // ****************************************
    ssq_state_t state;
    logic [1:0] ch_idx;
    logic [1:0] last_ch;
    logic [3:0] wptr;
    logic half;
    logic [3:0] seq_cnt;
    logic alt_phase;
    logic [3:0] scan_cur;
    logic [3:0] scan_first;
    logic [3:0] scan_next;
    logic done_ok;
    logic seq_end;
    logic irq_event;
    logic [3:0] buf_waddr;

    assign last_ch = last_chan(channel_count_select);
    assign done_ok = (state == SSQ_WAIT) && conv_done_i;
    assign seq_end = done_ok && (ch_idx == last_ch);
    assign irq_event = seq_end && (seq_cnt == sequences_per_interrupt);
    assign buf_waddr = buffer_split_select ? {half, wptr[2:0]} : wptr;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= SSQ_IDLE;
        end else if (!enable) begin
            state <= SSQ_IDLE;
        end else begin
            case (state)
                SSQ_IDLE: begin
                    if (auto_sample_enable || sw_sample) begin
                        state <= SSQ_SAMPLE;
                    end
                end
                SSQ_SAMPLE: begin
                    if (conv_trigger) begin
                        state <= SSQ_START;
                    end
                end
                SSQ_START: begin
                    state <= SSQ_WAIT;
                end
                SSQ_WAIT: begin
                    if (conv_done_i) begin
                        if (ch_idx != last_ch) begin
                            state <= SSQ_START;
                        end else if (auto_sample_enable) begin
                            state <= SSQ_SAMPLE;
                        end else begin
                            state <= SSQ_IDLE;
                        end
                    end
                end
                default: state <= SSQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ch_idx <= 2'h0;
        end else if (state == SSQ_SAMPLE || !enable) begin
            ch_idx <= 2'h0;
        end else if (done_ok && !seq_end) begin
            ch_idx <= ch_idx + 2'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= 4'h0;
            seq_cnt <= 4'h0;
            half <= 1'b0;
        end else if (!enable) begin
            wptr <= 4'h0;
            seq_cnt <= 4'h0;
            half <= 1'b0;
        end else if (done_ok) begin
            if (irq_event) begin
                wptr <= 4'h0;
                seq_cnt <= 4'h0;
                half <= buffer_split_select ? ~half : 1'b0;
            end else begin
                wptr <= wptr + 4'h1;
                if (seq_end) begin
                    seq_cnt <= seq_cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            alt_phase <= 1'b0;
        end else if (!alternate_set_select || !enable) begin
            alt_phase <= 1'b0;
        end else if (seq_end) begin
            alt_phase <= ~alt_phase;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            scan_cur <= 4'h0;
        end else if (!scan_enable || !enable) begin
            scan_cur <= scan_first;
        end else if (seq_end) begin
            scan_cur <= scan_next;
        end
    end

    ssq_scan_picker u_scan (
        .mask_i(scan_select_mask),
        .cur_i(scan_cur),
        .first_o(scan_first),
        .next_o(scan_next)
    );

    // ****************************************
    // result buffer
    // ****************************************
    logic [9:0] buf_rdata;

    ssq_result_buffer u_buf (
        .mclk_i(mclk_i),
        .we_i(done_ok),
        .waddr_i(buf_waddr),
        .wdata_i(conv_result_i),
        .raddr_i(bus_i.addr[5:2]),
        .rdata_o(buf_rdata)
    );

    // ****************************************
    // converter core and multiplexer outputs
    // ****************************************
    logic [3:0] act_mask;
    logic [3:0] later_mask;
    logic [3:0] c0_pos;
    logic c0_neg;
    logic c13_pos;
    logic [1:0] c13_neg;
    ssq_mux_t next_mux;

    assign act_mask = active_mask(channel_count_select);
    assign later_mask = act_mask & ~((4'h2 << ch_idx) - 4'h1);

    always_comb begin
        // second set only on alternate samples
        c0_pos = alt_phase ? insel[IS_C0P_B_LSB +: 4] : insel[IS_C0P_A_LSB +: 4];
        c0_neg = alt_phase ? insel[IS_C0N_B_BIT] : insel[IS_C0N_A_BIT];
        c13_pos = alt_phase ? insel[IS_C13P_B_BIT] : insel[IS_C13P_A_BIT];
        c13_neg = alt_phase ? insel[IS_C13N_B_LSB +: 2] : insel[IS_C13N_A_LSB +: 2];
        next_mux = '0;
        next_mux.pos[0] = scan_enable ? scan_cur : c0_pos;
        next_mux.neg[0] = c0_neg ? 4'h1 : 4'h0;
        next_mux.neg_ref[0] = !c0_neg;
        for (int k = 1; k < 4; k++) begin
            if (act_mask[k]) begin
                // fixed inputs: channel k takes k-1 or k+2, independent of scanning
                next_mux.pos[k] = c13_pos ? 4'(k + 2) : 4'(k - 1);
                next_mux.neg[k] = c13_neg[0] ? 4'(k + 8) : 4'(k + 5);
                next_mux.neg_ref[k] = !c13_neg[1];
            end else begin
                next_mux.neg_ref[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mux_o <= '0;
            sample_o <= 4'h0;
            conv_start_o <= 1'b0;
            conv_channel_o <= 2'h0;
        end else begin
            mux_o <= next_mux;
            conv_start_o <= (state == SSQ_START);
            conv_channel_o <= ch_idx;
            if (state == SSQ_SAMPLE) begin
                sample_o <= act_mask;
            end else if ((state == SSQ_START || state == SSQ_WAIT) && !sample_together_select &&
                         (last_ch != 2'h0)) begin
                // sequential: channels not yet converted keep tracking
                sample_o <= later_mask;
            end else begin
                sample_o <= 4'h0;
            end
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    logic [15:0] status_set;
    logic [15:0] status_clr;

    always_comb begin
        status_set = 16'h0000;
        status_set[ST_SEQ_BIT] = irq_event;
        status_set[ST_CONV_BIT] = done_ok;
        status_clr = (bus_i.we && is_addr(bus_i, OFF_STATUS)) ? bus_i.wdata : 16'h0000;
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            status <= RST_REG;
            irq_o <= 1'b0;
        end else begin
            status <= (status & ~status_clr) | status_set;
            irq_o <= |(status & irq_mask);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 16'h0000;
        end else if (!bus_i.re) begin
            rdata_o <= 16'h0000;
        end else if (bus_i.addr[7:6] == OFF_BUF[7:6] && bus_i.addr[1:0] == 2'h0) begin
            rdata_o <= {6'h00, buf_rdata};
        end else begin
            case (bus_i.addr)
                OFF_CTRL1: rdata_o <= ctrl1;
                OFF_CTRL2: rdata_o <= ctrl2;
                OFF_INSEL: rdata_o <= insel;
                OFF_SCAN: rdata_o <= scan_select_mask;
                OFF_STATUS: rdata_o <= status;
                OFF_MASK: rdata_o <= irq_mask;
                OFF_STATE: rdata_o <= {scan_cur, seq_cnt, wptr, half, alt_phase, ch_idx};
                default: rdata_o <= 16'h0000;
            endcase
        end
    end
endmodule

// ---- verification/ssq_core_model.sv ----
// behavioural converter core answering the sequencer's start pulses
`timescale 1ns/10ps
module ssq_core_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // from the sequencer
    input wire logic start_i,
    input wire logic [1:0] ch_i,
    input wire ssq_pkg::ssq_mux_t mux_i,
    // answer speed
    input wire logic slow_i,
    // to the sequencer
    output logic done_o,
    output logic [9:0] result_o
);
    import ssq_pkg::*;
    logic busy;
    logic [2:0] left;
    logic [3:0] num;
    logic [9:0] res;

    // result packs conversion count, channel and the input routed to it
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            left <= 3'h0;
            num <= 4'h0;
            res <= 10'h000;
        end else if (start_i) begin
            busy <= 1'b1;
            left <= slow_i ? 3'h5 : 3'h0;
            res <= {num, ch_i, mux_i.pos[ch_i]};
        end else if (busy && left == 3'h0) begin
            busy <= 1'b0;
            num <= num + 4'h1;
        end else if (busy) begin
            left <= left - 3'h1;
        end
    end

    assign done_o = busy && left == 3'h0;
    // outside the answer cycle the data lines show no stale result
    assign result_o = done_o ? res : ~res;
endmodule

// ---- verification/ssq_sequencer_chk.sv ----
// assertions on the sample sequencer ports
`timescale 1ns/10ps
module ssq_sequencer_chk (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire ssq_pkg::ssq_bus_req_t bus_i,
    input wire logic conv_trigger_i,
    input wire logic conv_start_o,
    input wire logic [1:0] conv_channel_o,
    input wire logic [3:0] sample_o,
    input wire ssq_pkg::ssq_mux_t mux_o
);
    import ssq_pkg::*;
    logic tog;
    logic [15:0] c2;
    logic [15:0] sel;
    logic [15:0] msk;
    logic [1:0] last_ch;

    // ****************
    // written settings
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog <= 1'b0;
            c2 <= 16'h0000;
            sel <= 16'h0000;
            msk <= 16'h0000;
        end else if (bus_i.we) begin
            case (bus_i.addr)
                OFF_CTRL1: tog <= bus_i.wdata[CTL_TOGETHER_BIT];
                OFF_CTRL2: c2 <= bus_i.wdata;
                OFF_INSEL: sel <= bus_i.wdata;
                OFF_SCAN: msk <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (conv_start_o) begin
            last_ch <= conv_channel_o;
        end
    end

    // ****************
    // properties
    // ****************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_trig_seen;
        $rose(conv_trigger_i) && sample_o[0];
    endsequence
    sequence s_first_conv;
        conv_start_o && conv_channel_o == 2'd0;
    endsequence

    chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    chk_trig_start: assert property (s_trig_seen |-> ##[1:8] conv_start_o)
        else $error("trigger did not start conversion");
    chk_start_held: assert property (conv_start_o |-> !sample_o[conv_channel_o])
        else $error("converted channel still sampling");
    chk_chan_order: assert property (
        conv_start_o && conv_channel_o != 2'd0 |-> conv_channel_o == last_ch + 2'd1)
        else $error("channel conversion order wrong");
    chk_all_held: assert property (
        (tog && c2[9]) ##0 s_first_conv |-> $past(sample_o) == 4'hF)
        else $error("channels not sampled together");
    chk_mux_fixed: assert property (
        sample_o[0] && !c2[C2_SCAN_BIT] && !c2[C2_ALT_BIT] && $stable(sel)
        |-> mux_o.pos[0] == sel[3:0] && mux_o.neg_ref[0] == !sel[4])
        else $error("channel 0 routing wrong");
    chk_scan_mask: assert property (
        sample_o[0] && c2[C2_SCAN_BIT] && msk != 16'h0000 && $stable(msk) |-> msk[mux_o.pos[0]])
        else $error("scanned input not in mask");
    chk_fixed_in: assert property (
        sample_o[3] && !c2[C2_ALT_BIT] && $stable(sel) |-> mux_o.pos[1] == (sel[5] ? 4'h3 : 4'h0)
        && mux_o.pos[2] == mux_o.pos[1] + 4'h1 && mux_o.pos[3] == mux_o.pos[1] + 4'h2)
        else $error("channel 1 to 3 routing wrong");
endmodule

bind ssq_sequencer ssq_sequencer_chk u_ssq_sequencer_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .conv_trigger_i(conv_trigger_i),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .sample_o(sample_o), .mux_o(mux_o)
);

// ---- verification/tb.sv ----
// self-checking bench of the sample sequencer
`timescale 1ns/10ps
`define check_eq(what, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", what, exp, got); end end
module tb;
    import ssq_pkg::*;
    typedef struct {
        logic [15:0] c1;
        logic [15:0] c2;
        logic [15:0] insel;
        logic [15:0] mask;
        logic slow;
    } ssq_row_t;
    logic mclk_i = 1'b0;
    logic rst_n_i;
    ssq_bus_req_t bus_i;
    logic conv_trigger_i;
    logic slow;
    logic conv_done_i;
    logic [9:0] conv_result_i;
    logic conv_start_o;
    logic [1:0] conv_channel_o;
    logic [3:0] sample_o;
    ssq_mux_t mux_o;
    logic irq_o;
    logic [15:0] rdata_o;
    logic [15:0] d;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    ssq_row_t rows [5];

    always #2.5 mclk_i = ~mclk_i;

    ssq_sequencer u_ssq_sequencer (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .conv_trigger_i(conv_trigger_i), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
        .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .sample_o(sample_o),
        .mux_o(mux_o), .irq_o(irq_o)
    );
    ssq_core_model u_ssq_core_model (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(conv_start_o), .ch_i(conv_channel_o),
        .mux_i(mux_o), .slow_i(slow), .done_o(conv_done_i), .result_o(conv_result_i)
    );

    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        bus_i <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge mclk_i);
        bus_i <= '0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [7:0] a);
        bus_i <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge mclk_i);
        bus_i <= '0;
        @(negedge mclk_i);
        d = rdata_o;
        @(posedge mclk_i);
    endtask

    // s-th enabled input of the scan mask, ascending with wrap
    function automatic logic [3:0] scan_pos(input logic [15:0] m, input int s);
        int n;
        n = 0;
        for (int r = 0; r < 256; r++) begin
            if (m[r % 16]) begin
                if (n == s) return 4'(r % 16);
                n++;
            end
        end
        return 4'h0;
    endfunction

    function automatic logic [9:0] exp_word(input ssq_row_t r, input int i);
        int nch;
        int c;
        logic [3:0] p;
        nch = r.c2[9] ? 4 : (r.c2[8] ? 2 : 1);
        c = i % nch;
        p = r.c2[C2_SCAN_BIT] ? scan_pos(r.mask, i / nch) : r.insel[3:0];
        if (c != 0) p = 4'(c - 1 + (r.insel[5] ? 3 : 0));
        return {4'(i), 2'(c), p};
    endfunction

    task automatic run_row(input ssq_row_t r);
        wr(OFF_CTRL1, 16'h0000);
        wr(OFF_STATUS, 16'h0003);
        wr(OFF_MASK, 16'h0001);
        wr(OFF_CTRL2, r.c2);
        wr(OFF_INSEL, r.insel);
        wr(OFF_SCAN, r.mask);
        slow <= r.slow;
        wr(OFF_CTRL1, r.c1);
        repeat (int'(r.c2[5:2]) + 1) begin
            @(posedge mclk_i iff sample_o[0]);
            `check_eq("irq early", 1'b0, irq_o)
            conv_trigger_i <= 1'b1;
            @(posedge mclk_i iff conv_start_o);
            conv_trigger_i <= 1'b0;
        end
        @(posedge mclk_i iff irq_o);
        rd(OFF_STATE);
        `check_eq("seq and wptr", 8'h00, d[11:4])
        for (int i = 0; i < BUF_WORDS; i++) begin
            rd(OFF_BUF + 8'(4 * i));
            `check_eq("word", exp_word(r, i), d[9:0])
        end
    endtask

    initial begin
        rst_n_i = 1'b0;
        bus_i = '0;
        conv_trigger_i = 1'b0;
        slow = 1'b0;
        rows[0] = '{16'h0003, 16'h011C, 16'hFF13, 16'h0000, 1'b0};
        rows[1] = '{16'h0007, 16'h060C, 16'hFF00, 16'h00F0, 1'b1};
        rows[2] = '{16'h0003, 16'h030C, 16'h0025, 16'h0000, 1'b0};
        rows[3] = '{16'h0003, 16'h043C, 16'hFF07, 16'hFFFF, 1'b1};
        rows[4] = '{16'h0007, 16'h003C, 16'hFF00, 16'h0000, 1'b0};
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        foreach (rows[k]) begin
            run_row(rows[k]);
        end
        // interrupt masking and sticky clear
        wr(OFF_MASK, 16'h0000);
        @(posedge mclk_i);
        `check_eq("irq masked", 1'b0, irq_o)
        rd(OFF_STATUS);
        `check_eq("status", 16'h0003, d)
        wr(OFF_MASK, 16'h0001);
        @(posedge mclk_i);
        `check_eq("irq unmasked", 1'b1, irq_o)
        wr(OFF_STATUS, 16'h0003);
        @(posedge mclk_i);
        `check_eq("irq cleared", 1'b0, irq_o)
        // next sequence runs on without software restart
        @(posedge mclk_i iff sample_o[0]);
        conv_trigger_i <= 1'b1;
        @(posedge mclk_i iff conv_done_i);
        conv_trigger_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rd(OFF_STATE);
        `check_eq("wptr", 4'h1, d[7:4])
        wr(8'h30, 16'hFFFF);
        rd(8'h30);
        `check_eq("unmapped", 16'h0000, d)
        // reset in mid-run
        rst_n_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        `check_eq("sample in reset", 4'h0, sample_o)
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(OFF_CTRL2);
        `check_eq("ctrl2 reset", RST_REG, d)
        print_verdict();
    end
endmodule
